// [logic/dssl_pkg.sv]
// Purpose: shared constants and types for the dual-slope sequencer and lcd drive
// Assumes: clk is the converter oscillator
// Notes: all counts are in converter counts except BP_DIV and OSC_PER_COUNT, which are in oscillator cycles
`default_nettype none

package dssl_pkg;

  // oscillator cycles per converter count
  localparam int unsigned OSC_PER_COUNT = 4;
  localparam int unsigned PRESC_W = 2;
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(OSC_PER_COUNT - 1);

  localparam int unsigned CNT_W = 12;
  localparam int unsigned AZ_MIN_COUNTS = 1000;
  localparam int unsigned AZ_MAX_COUNTS = 3000;
  localparam int unsigned INTEG_COUNTS = 1000;
  localparam int unsigned DEINT_MAX_COUNTS = 2000;
  localparam int unsigned CYCLE_COUNTS = 4000;

  // backplane period in oscillator cycles
  localparam int unsigned BP_DIV = 800;
  localparam int unsigned BP_W = 9;

  localparam int unsigned DIGITS = 4;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [3:0] BCD_ZERO = 4'h0;

  typedef enum logic [1:0] {
    PH_ZERO = 2'b00,
    PH_INTEG = 2'b01,
    PH_DEINT = 2'b10
  } dssl_phase_t;

  typedef struct packed {
    logic inputs_connect;
    logic nodes_to_common;
    logic az_loop_close;
    logic low_to_common;
    logic ref_direct;
    logic ref_reversed;
  } dssl_analog_t;

  localparam dssl_analog_t ANALOG_ZERO = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic minus;
    logic thousands;
    logic [6:0] hundreds;
    logic [6:0] tens;
    logic [6:0] ones;
  } dssl_seg_t;

endpackage : dssl_pkg

`default_nettype wire

// [logic/dssl_top.sv]
// Purpose: dual-slope converter sequencer with direct lcd segment and backplane drive
// Assumes: clk is the oscillator; comparator and lamp test arrive asynchronously from pins
// Notes: segment bits are abcdefg with a in bit 6; the thousands output drives b and c together
//
// Contract
// - run zero, integrate, de-integrate phases in that order, forever.
// - zero phase lasts 1000 to 3000 counts, set by unused de-integration time.
// - signal integration lasts exactly 1000 counts.
// - one count every four oscillator cycles.
// - zero phase opens inputs, shorts nodes to common, closes offset loop.
// - integration connects inputs to high and low pins, offset loop open.
// - latch polarity from comparator at end of integration, valid below one count.
// - de-integration ties low to common, reference polarity opposes latched sign.
// - de-integration ends on zero crossing, 0 to 2000 counts, count is result.
// - displayed reading equals the de-integration count; over-range shows 1999.
// - backplane square wave at oscillator frequency divided by 800.
// - segment in phase with backplane is off, antiphase is on.
// - minus segment on when latched polarity is negative.
// - lamp test forces all segments on as constant level; keep it brief.
// - every measurement cycle after the first one following reset totals 4000 counts.
// - unused de-integration counts extend the following zero phase.
`default_nettype none

module dssl_top
  import dssl_pkg::*;
#(
  parameter int unsigned AZ_MIN = dssl_pkg::AZ_MIN_COUNTS,
  parameter int unsigned AZ_MAX = dssl_pkg::AZ_MAX_COUNTS,
  parameter int unsigned INTEG = dssl_pkg::INTEG_COUNTS,
  parameter int unsigned DEINT_MAX = dssl_pkg::DEINT_MAX_COUNTS,
  parameter int unsigned BP_DIVIDE = dssl_pkg::BP_DIV
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic comparator_in,
  input wire logic lamp_test_in,
  output dssl_pkg::dssl_analog_t analog_ctrl_o,
  output dssl_pkg::dssl_phase_t phase_o,
  output logic count_tick_o,
  output logic backplane_o,
  output dssl_pkg::dssl_seg_t segments_o,
  output logic [dssl_pkg::CNT_W-1:0] result_count_o,
  output logic result_negative_o,
  output logic overrange_o,
  output logic result_valid_o
);
  import dssl_pkg::*;

  localparam logic [CNT_W-1:0] AZ_MIN_C = CNT_W'(AZ_MIN);
  localparam logic [CNT_W-1:0] AZ_MAX_C = CNT_W'(AZ_MAX);
  localparam logic [CNT_W-1:0] INTEG_LAST = CNT_W'(INTEG - 1);
  localparam logic [CNT_W-1:0] DEINT_MAX_C = CNT_W'(DEINT_MAX);
  localparam logic [CNT_W-1:0] DEINT_LAST = CNT_W'(DEINT_MAX - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [BP_W-1:0] BP_HALF_LAST = BP_W'(BP_DIVIDE / 2 - 1);

  function automatic logic [6:0] seven_seg(input logic [3:0] d);
    logic [6:0] s;
    s = 7'h00;
    case (d)
      4'h0: s = 7'h7E;
      4'h1: s = 7'h30;
      4'h2: s = 7'h6D;
      4'h3: s = 7'h79;
      4'h4: s = 7'h33;
      4'h5: s = 7'h5B;
      4'h6: s = 7'h5F;
      4'h7: s = 7'h70;
      4'h8: s = 7'h7F;
      4'h9: s = 7'h7B;
      default: s = 7'h00;
    endcase
    return s;
  endfunction : seven_seg

  // pin synchronisers; only the second stage is read
  logic comp_meta_q;
  logic comp_s_q;
  logic lamp_meta_q;
  logic lamp_s_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      comp_meta_q <= 1'b0;
      comp_s_q <= 1'b0;
      lamp_meta_q <= 1'b0;
      lamp_s_q <= 1'b0;
    end else begin
      comp_meta_q <= comparator_in;
      comp_s_q <= comp_meta_q;
      lamp_meta_q <= lamp_test_in;
      lamp_s_q <= lamp_meta_q;
    end
  end

  // count prescaler
  logic [PRESC_W-1:0] presc_q;
  logic tick;

  assign tick = (presc_q == PRESC_LAST);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + PRESC_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_tick_o <= 1'b0;
    end else begin
      count_tick_o <= tick;
    end
  end

  // phase sequencer
  dssl_phase_t state_q;
  dssl_phase_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] zero_len_q;
  logic comp_ref_q;
  logic neg_q;
  logic crossing;
  logic deint_end;
  logic deint_over;
  logic integ_end;

  // comparator leaving the level it held at integration end marks the zero crossing
  assign crossing = (comp_s_q != comp_ref_q);
  assign integ_end = tick && (state_q == PH_INTEG) && (cnt_q == INTEG_LAST);
  assign deint_end = tick && (state_q == PH_DEINT) && (crossing || cnt_q == DEINT_LAST);
  assign deint_over = deint_end && !crossing;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PH_ZERO: begin
        if (tick && cnt_q == zero_len_q - CNT_ONE) begin
          state_d = PH_INTEG;
        end
      end
      PH_INTEG: begin
        if (integ_end) begin
          state_d = PH_DEINT;
        end
      end
      PH_DEINT: begin
        if (deint_end) begin
          state_d = PH_ZERO;
        end
      end
      default: state_d = PH_ZERO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= PH_ZERO;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        cnt_q <= '0;
      end else if (tick) begin
        cnt_q <= cnt_q + CNT_ONE;
      end
    end
  end

  // first cycle after reset uses the longest zero phase
  always_ff @(posedge clk) begin
    if (!resetn) begin
      zero_len_q <= AZ_MAX_C;
    end else if (deint_end) begin
      if (deint_over) begin
        zero_len_q <= AZ_MIN_C;
      end else begin
        // ending tick counts as used, so the whole cycle stays constant
        zero_len_q <= AZ_MIN_C + DEINT_LAST - cnt_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      comp_ref_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (integ_end) begin
      // sign is pure comparator state, so sub-count inputs still resolve
      comp_ref_q <= comp_s_q;
      neg_q <= !comp_s_q;
    end
  end

  // analog switch controls, registered from the next phase so they align with phase_o
  always_ff @(posedge clk) begin
    if (!resetn) begin
      analog_ctrl_o <= ANALOG_ZERO;
      phase_o <= PH_ZERO;
    end else begin
      phase_o <= state_d;
      analog_ctrl_o <= '0;
      case (state_d)
        PH_ZERO: analog_ctrl_o <= ANALOG_ZERO;
        PH_INTEG: analog_ctrl_o.inputs_connect <= 1'b1;
        PH_DEINT: begin
          analog_ctrl_o.low_to_common <= 1'b1;
          // positive input needs the reference reversed to ramp back
          analog_ctrl_o.ref_reversed <= integ_end ? comp_s_q : !neg_q;
          analog_ctrl_o.ref_direct <= integ_end ? !comp_s_q : neg_q;
        end
        default: analog_ctrl_o <= ANALOG_ZERO;
      endcase
    end
  end

  // decade counters for the reading
  logic [3:0] bcd_q [DIGITS];
  logic [DIGITS:0] carry;
  logic bcd_clr;

  assign bcd_clr = integ_end;
  assign carry[0] = tick && (state_q == PH_DEINT) && !deint_end;

  genvar gi;
  generate
    for (gi = 0; gi < DIGITS; gi++) begin : g_decade
      assign carry[gi+1] = carry[gi] && (bcd_q[gi] == BCD_NINE);
      always_ff @(posedge clk) begin
        if (!resetn) begin
          bcd_q[gi] <= BCD_ZERO;
        end else if (bcd_clr) begin
          bcd_q[gi] <= BCD_ZERO;
        end else if (carry[gi]) begin
          bcd_q[gi] <= (bcd_q[gi] == BCD_NINE) ? BCD_ZERO : bcd_q[gi] + 4'h1;
        end
      end
    end
  endgenerate

  // display latch and result
  logic [3:0] disp_q [3];
  logic disp_thou_q;
  logic disp_neg_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      disp_q[0] <= BCD_ZERO;
      disp_q[1] <= BCD_ZERO;
      disp_q[2] <= BCD_ZERO;
      disp_thou_q <= 1'b0;
      disp_neg_q <= 1'b0;
    end else if (deint_end) begin
      // over-range leaves the decades at the top of scale
      disp_q[0] <= bcd_q[0];
      disp_q[1] <= bcd_q[1];
      disp_q[2] <= bcd_q[2];
      disp_thou_q <= (bcd_q[3] != BCD_ZERO);
      disp_neg_q <= neg_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_count_o <= '0;
      result_negative_o <= 1'b0;
      overrange_o <= 1'b0;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= deint_end;
      if (deint_end) begin
        result_count_o <= deint_over ? DEINT_MAX_C : cnt_q;
        result_negative_o <= neg_q;
        overrange_o <= deint_over;
      end
    end
  end

  // lcd backplane and segment drive
  logic [BP_W-1:0] bp_cnt_q;
  logic bp_q;
  logic bp_d;
  dssl_seg_t seg_on;

  assign bp_d = (bp_cnt_q == BP_HALF_LAST) ? !bp_q : bp_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bp_cnt_q <= '0;
      bp_q <= 1'b0;
    end else begin
      bp_cnt_q <= (bp_cnt_q == BP_HALF_LAST) ? '0 : bp_cnt_q + BP_W'(1);
      bp_q <= bp_d;
    end
  end

  always_comb begin
    seg_on.minus = disp_neg_q;
    seg_on.thousands = disp_thou_q;
    seg_on.hundreds = seven_seg(disp_q[2]);
    seg_on.tens = seven_seg(disp_q[1]);
    seg_on.ones = seven_seg(disp_q[0]);
  end

  // lamp test holds dc on the glass; the panel only tolerates this briefly
  always_ff @(posedge clk) begin
    if (!resetn) begin
      backplane_o <= 1'b0;
      segments_o <= '0;
    end else if (lamp_s_q) begin
      backplane_o <= 1'b0;
      segments_o <= '1;
    end else begin
      backplane_o <= bp_d;
      segments_o <= seg_on ^ {$bits(dssl_seg_t){bp_d}};
    end
  end

endmodule : dssl_top

`default_nettype wire

// [test/dssl_chk.sv]
// Purpose: port assertions for dssl_top
// Assumes: phase lengths are taken in clk cycles from phase_o changes
// Notes: the first zero phase and the first cycle after reset are not timed
`default_nettype none
module dssl_chk
  import dssl_pkg::*;
#(
  parameter int unsigned AZ_MIN = 1000,
  parameter int unsigned AZ_MAX = 3000,
  parameter int unsigned INTEG = 1000,
  parameter int unsigned DEINT_MAX = 2000,
  parameter int unsigned BP_DIVIDE = 800
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic lamp_test_in,
  input wire dssl_pkg::dssl_analog_t analog_ctrl_o,
  input wire dssl_pkg::dssl_phase_t phase_o,
  input wire logic count_tick_o,
  input wire logic backplane_o,
  input wire dssl_pkg::dssl_seg_t segments_o,
  input wire logic result_valid_o,
  input wire logic result_negative_o
);
  timeunit 1ns;
  timeprecision 100ps;
  dssl_phase_t ph_q;
  logic [15:0] len_q, cyc_q, bp_q;
  logic bpl_q, bp_ok_q, cyc_ok_q;
  logic [3:0] lamp_sh_q;
  wire logic ph_new = phase_o != ph_q;
  wire logic bp_edge = backplane_o != bpl_q;
  always_ff @(posedge clk) begin
    ph_q <= resetn ? phase_o : PH_ZERO;
    len_q <= (!resetn || ph_new) ? 16'h1 : len_q + 16'h1;
  end
  always_ff @(posedge clk) begin
    cyc_q <= (!resetn || (ph_new && phase_o == PH_INTEG)) ? 16'h1 : cyc_q + 16'h1;
    cyc_ok_q <= resetn && (cyc_ok_q || (ph_new && phase_o == PH_INTEG));
  end
  // lamp test parks the backplane and its release can show a false edge,
  // so the period is trusted only after the pin has settled low and a clean edge follows
  always_ff @(posedge clk) begin
    bpl_q <= backplane_o;
    bp_q <= bp_edge ? 16'h1 : bp_q + 16'h1;
    lamp_sh_q <= {lamp_sh_q[2:0], lamp_test_in};
    bp_ok_q <= resetn && !lamp_test_in && lamp_sh_q == 4'h0 && (bp_ok_q || bp_edge);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_gap;
    !count_tick_o [*3] ##1 count_tick_o;
  endsequence
  a_tick_spacing: assert property (count_tick_o |=> s_gap)
    else $error("count tick spacing wrong");
  a_phase_order: assert property (ph_new |-> phase_o == (ph_q == PH_ZERO ? PH_INTEG :
    ph_q == PH_INTEG ? PH_DEINT : PH_ZERO)) else $error("phase order wrong");
  a_integ_len: assert property (ph_new && ph_q == PH_INTEG |-> len_q == INTEG * 4)
    else $error("integrate length wrong");
  a_zero_len: assert property (ph_new && ph_q == PH_ZERO && cyc_ok_q |->
    len_q >= AZ_MIN * 4 && len_q <= AZ_MAX * 4) else $error("zero length out of range");
  a_cycle_len: assert property (ph_new && phase_o == PH_INTEG && cyc_ok_q |->
    cyc_q == (AZ_MIN + INTEG + DEINT_MAX) * 4) else $error("cycle length wrong");
  a_zero_switch: assert property (phase_o == PH_ZERO |-> analog_ctrl_o == ANALOG_ZERO)
    else $error("zero switches wrong");
  a_integ_switch: assert property (phase_o == PH_INTEG |-> analog_ctrl_o == 6'h20)
    else $error("integrate switches wrong");
  a_deint_switch: assert property (phase_o == PH_DEINT |-> analog_ctrl_o.low_to_common &&
    (analog_ctrl_o.ref_direct ^ analog_ctrl_o.ref_reversed)) else $error("reference switches wrong");
  a_ref_polarity: assert property (result_valid_o |-> $past(analog_ctrl_o.ref_direct) == result_negative_o)
    else $error("reference polarity wrong");
  a_lamp_force: assert property (lamp_test_in && $past(lamp_test_in, 4) |->
    segments_o == 23'h7FFFFF && !backplane_o) else $error("lamp test not forcing");
  a_seg_antiphase: assert property (bp_edge && bp_ok_q && !result_valid_o && !$past(result_valid_o) |->
    segments_o == ~$past(segments_o)) else $error("segments not following backplane");
  a_bp_period: assert property (bp_edge && bp_ok_q |-> bp_q == BP_DIVIDE / 2)
    else $error("backplane half period wrong");
endmodule : dssl_chk

bind dssl_top dssl_chk #(.AZ_MIN(AZ_MIN), .AZ_MAX(AZ_MAX), .INTEG(INTEG), .DEINT_MAX(DEINT_MAX),
  .BP_DIVIDE(BP_DIVIDE)) u_chk (.clk, .resetn, .lamp_test_in, .analog_ctrl_o, .phase_o, .count_tick_o,
  .backplane_o, .segments_o, .result_valid_o, .result_negative_o);
`default_nettype wire

// [test/dssl_front_model.sv]
// Purpose: behavioural integrator and comparator in front of dssl_top
// Assumes: level and negative change only in the zero phase
// Notes: the ramp back to zero takes level count ticks
`default_nettype none
module dssl_front_model
  import dssl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire dssl_pkg::dssl_phase_t phase_o,
  input wire logic count_tick_o,
  input wire logic [11:0] level,
  input wire logic negative,
  output logic comparator_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] ticks_q;
  always_ff @(posedge clk) begin
    if (!resetn || phase_o != PH_DEINT) begin
      ticks_q <= 12'h0;
    end else if (count_tick_o) begin
      ticks_q <= ticks_q + 12'h1;
    end
  end
  // stays on the input's side until the reference has cancelled level counts
  assign comparator_in = !negative ^ (phase_o == PH_DEINT && ticks_q > level);
endmodule : dssl_front_model
`default_nettype wire

// [test/dssl_top_tb_top.sv]
// Purpose: self-checking bench for dssl_top
// Assumes: shortened counts give 160 clk per conversion
// Notes: the driver queues readings, a watcher pops them on result_valid_o
`default_nettype none
module dssl_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dssl_pkg::*;
  typedef struct packed {
    logic [11:0] c;
    logic n;
    logic o;
    logic [22:0] s;
  } dssl_exp_t;
  localparam logic [6:0] SEVEN [10] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F, 7'h70, 7'h7F, 7'h7B};
  localparam int LV [6] = '{0, 0, 1, 19, 20, 25};
  localparam int DMX = 20;
  logic clk, resetn, comparator_in, lamp_test_in, count_tick_o, backplane_o, result_negative_o;
  logic overrange_o, result_valid_o, negative;
  logic [11:0] level, result_count_o;
  logic [31:0] r;
  dssl_analog_t analog_ctrl_o;
  dssl_phase_t phase_o;
  dssl_seg_t segments_o;
  dssl_exp_t exp_q[$];
  dssl_exp_t e, w;
  int fails = 0;
  int checks = 0;
  int seed = 74;
  int d;
  dssl_top #(.AZ_MIN(10), .AZ_MAX(30), .INTEG(10), .DEINT_MAX(DMX), .BP_DIVIDE(8)) dut (.clk, .resetn,
    .comparator_in, .lamp_test_in, .analog_ctrl_o, .phase_o, .count_tick_o, .backplane_o, .segments_o,
    .result_count_o, .result_negative_o, .overrange_o, .result_valid_o);
  dssl_front_model u_front (.clk, .resetn, .phase_o, .count_tick_o, .level, .negative, .comparator_in);
  task automatic print_verdict();
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [23:0] got, input logic [23:0] want);
    checks++;
    if (got !== want) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, want);
    end
  endtask : cmp
  task automatic wait_ph(input dssl_phase_t t);
    int k;
    k = 0;
    while (phase_o !== t && k < 400) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 400) begin
      fails++;
      print_verdict();
    end
  endtask : wait_ph
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // outputs are read 1 ns after the edge; the glass follows the result flag by one clock
  initial forever begin
    @(posedge clk);
    #1;
    if (result_valid_o === 1'b1) begin
      if (exp_q.size() != 0) w = exp_q.pop_front();
      else w = '1;
      cmp({overrange_o, result_negative_o, result_count_o}, {w.o, w.n, w.c});
      @(posedge clk);
      #1;
      cmp({1'b0, segments_o ^ {23{backplane_o}}}, {1'b0, w.s});
    end
  end
  initial begin
    resetn = 1'b0;
    lamp_test_in = 1'b0;
    level = 12'h0;
    negative = 1'b0;
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    for (int i = 0; i < 14; i++) begin
      wait_ph(PH_ZERO);
      r = $random(seed);
      level = i < 6 ? 12'(LV[i]) : 12'(r % 32'd26);
      negative = i < 6 ? i[0] : r[8];
      e.c = level < DMX ? level : 12'(DMX);
      e.n = negative;
      e.o = level >= DMX;
      // over-range leaves the decades one below the limit
      d = e.o ? DMX - 1 : int'(e.c);
      e.s = {negative, 1'b0, SEVEN[0], SEVEN[d / 10], SEVEN[d % 10]};
      exp_q.push_back(e);
      wait_ph(PH_INTEG);
      if (i == 6) begin
        lamp_test_in = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        cmp({backplane_o, segments_o}, 24'h7FFFFF);
        lamp_test_in = 1'b0;
      end
      wait_ph(PH_ZERO);
    end
    repeat (8) @(posedge clk);
    cmp(24'(exp_q.size()), 24'h0);
    print_verdict();
  end
endmodule : dssl_top_tb_top
`default_nettype wire
